// ### shared/eeir_pkg.sv
package eeir_pkg;
    // register word indices; the byte address is the index times four
    localparam logic [7:0] IDX_MACH_LO = 8'h0b;
    localparam logic [7:0] IDX_MACH_HI = 8'h0c;
    localparam logic [7:0] IDX_CLS = 8'h0d;
    localparam logic [7:0] IDX_PIN2 = 8'h0e;
    localparam logic [7:0] IDX_CFG1 = 8'h5e;
    localparam logic [7:0] IDX_CFG2 = 8'h5f;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
    localparam int ADDR_W = 10;
    // field positions in the second-pin route register
    localparam int POS_LONG_CNT = 7;
    localparam int POS_SIG_MOT = 5;
    localparam int POS_TILT = 4;
    localparam int POS_STEP = 3;
    localparam logic [7:0] PIN2_USED_MASK = 8'hb8;
    // gate bit position in each pin config register
    localparam int POS_GATE = 1;
    localparam logic [7:0] ROUTE_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;
    // status bit positions: rising edge of each pin
    localparam int POS_IRQ_PIN1 = 0;
    localparam int POS_IRQ_PIN2 = 1;

    typedef struct packed {
        logic [15:0] machine;
        logic [7:0] classifier;
        logic longCounter;
        logic sigMotion;
        logic tilt;
        logic step;
    } eeir_events_t;

    typedef enum logic [2:0] {
        EEIR_IDLE = 3'b001,
        EEIR_ACK = 3'b010,
        EEIR_DONE = 3'b100
    } eeir_bus_state_t;
endpackage

// ### hw/eeir_top.sv
// Operation
// - each pin ORs its enabled event sources
// - route register low: machines one to eight
// - route register high: machines nine to sixteen
// - classifier register routes classifiers one-eight
// - pin one bit: zero blocks, one passes
// - pin two bit: zero blocks, one passes
// - all routing bits reset to zero
// - pin one routing needs pin one gate
// - pin two routing needs pin two gate
// - pin two route bit for long counter
// - pin two route bit for significant motion
// - pin two route bit for tilt
// - pin two route bit for step event
// - pin one route registers read back
// - pin two route register reads back
module eeir_top (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [eeir_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire eeir_pkg::eeir_events_t events,
    output logic firstInterruptPin,
    output logic secondInterruptPin,
    output logic irq
);

    // ********************************
    // bus slave
    // ********************************
    eeir_pkg::eeir_bus_state_t busState_q;
    logic [7:0] machLo_q;
    logic [7:0] machHi_q;
    logic [7:0] cls_q;
    logic [7:0] pin2_q;
    logic [7:0] cfg1_q;
    logic [7:0] cfg2_q;
    logic [1:0] irqStat_q;
    logic [1:0] irqMask_q;
    logic [31:0] rdData_d;
    logic req;
    logic wrEn;
    logic [7:0] wordIdx;
    logic [7:0] wrByte;

    assign req = wb_cyc_i && wb_stb_i;
    assign wordIdx = wb_adr_i[eeir_pkg::ADDR_W-1:2];
    assign wrByte = wb_dat_i[7:0];
    assign wrEn = req && wb_we_i && wb_sel_i[0]
                  && busState_q == eeir_pkg::EEIR_IDLE;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busState_q <= eeir_pkg::EEIR_IDLE;
        end else begin
            case (busState_q)
                eeir_pkg::EEIR_IDLE: begin
                    if (req) begin
                        busState_q <= eeir_pkg::EEIR_ACK;
                    end
                end
                eeir_pkg::EEIR_ACK: begin
                    busState_q <= eeir_pkg::EEIR_DONE;
                end
                eeir_pkg::EEIR_DONE: begin
                    if (!req) begin
                        busState_q <= eeir_pkg::EEIR_IDLE;
                    end
                end
                default: begin
                    busState_q <= eeir_pkg::EEIR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && busState_q == eeir_pkg::EEIR_IDLE;
        end
    end

    // ********************************
    // routing registers
    // ********************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            machLo_q <= eeir_pkg::ROUTE_RST;
            machHi_q <= eeir_pkg::ROUTE_RST;
            cls_q <= eeir_pkg::ROUTE_RST;
            pin2_q <= eeir_pkg::ROUTE_RST;
            cfg1_q <= eeir_pkg::ROUTE_RST;
            cfg2_q <= eeir_pkg::ROUTE_RST;
            irqMask_q <= eeir_pkg::IRQ_RST;
        end else if (wrEn) begin
            case (wordIdx)
                eeir_pkg::IDX_MACH_LO: machLo_q <= wrByte;
                eeir_pkg::IDX_MACH_HI: machHi_q <= wrByte;
                eeir_pkg::IDX_CLS: cls_q <= wrByte;
                // unused bits are stored as written; software keeps them 0
                eeir_pkg::IDX_PIN2: pin2_q <= wrByte;
                eeir_pkg::IDX_CFG1: cfg1_q <= wrByte;
                eeir_pkg::IDX_CFG2: cfg2_q <= wrByte;
                eeir_pkg::IDX_IRQ_MASK: irqMask_q <= wrByte[1:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdData_d = 32'h0;
        case (wordIdx)
            eeir_pkg::IDX_MACH_LO: rdData_d[7:0] = machLo_q;
            eeir_pkg::IDX_MACH_HI: rdData_d[7:0] = machHi_q;
            eeir_pkg::IDX_CLS: rdData_d[7:0] = cls_q;
            eeir_pkg::IDX_PIN2: rdData_d[7:0] = pin2_q;
            eeir_pkg::IDX_CFG1: rdData_d[7:0] = cfg1_q;
            eeir_pkg::IDX_CFG2: rdData_d[7:0] = cfg2_q;
            eeir_pkg::IDX_IRQ_STAT: rdData_d[1:0] = irqStat_q;
            eeir_pkg::IDX_IRQ_MASK: rdData_d[1:0] = irqMask_q;
            default: rdData_d = 32'h0;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0;
        end else if (req && busState_q == eeir_pkg::EEIR_IDLE) begin
            wb_dat_o <= rdData_d;
        end
    end

    // ********************************
    // routing logic
    // ********************************
    logic pin1_d;
    logic pin2_d;
    logic [3:0] pin2Src;
    logic [3:0] pin2En;

    assign pin2Src = {events.longCounter, events.sigMotion,
                      events.tilt, events.step};
    assign pin2En = {pin2_q[eeir_pkg::POS_LONG_CNT],
                     pin2_q[eeir_pkg::POS_SIG_MOT],
                     pin2_q[eeir_pkg::POS_TILT],
                     pin2_q[eeir_pkg::POS_STEP]};

    // bit i of the low and classifier route registers passes source i; bit i of the high register passes machine 8+i
    assign pin1_d = cfg1_q[eeir_pkg::POS_GATE]
        && (|({machHi_q, machLo_q} & events.machine)
            || |(cls_q & events.classifier));
    assign pin2_d = cfg2_q[eeir_pkg::POS_GATE]
        && |(pin2En & pin2Src);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            firstInterruptPin <= 1'b0;
            secondInterruptPin <= 1'b0;
        end else begin
            firstInterruptPin <= pin1_d;
            secondInterruptPin <= pin2_d;
        end
    end

    // ********************************
    // interrupt status
    // ********************************
    logic [1:0] rise;
    logic [1:0] clr;

    assign rise = {pin2_d && !secondInterruptPin,
                   pin1_d && !firstInterruptPin};
    assign clr = (wrEn && wordIdx == eeir_pkg::IDX_IRQ_STAT)
                 ? wrByte[1:0] : 2'h0;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irqStat_q <= eeir_pkg::IRQ_RST;
        end else begin
            irqStat_q <= (irqStat_q & ~clr) | rise;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // ********************************
    // checks
    // ********************************
    chk_route_reset: assert property (
        @(posedge clock) $rose(rstn) |-> machLo_q == 8'h0 && pin2_q == 8'h0)
        else $error("route regs not cleared by reset");
    chk_pin_one_or: assert property (@(posedge clock) disable iff (!rstn)
        firstInterruptPin == $past(pin1_d))
        else $error("pin one not from routed OR");
    chk_gate_one: assert property (@(posedge clock) disable iff (!rstn)
        !cfg1_q[1] |=> !firstInterruptPin)
        else $error("pin one active with gate off");
    chk_gate_two: assert property (@(posedge clock) disable iff (!rstn)
        !cfg2_q[1] |=> !secondInterruptPin)
        else $error("pin two active with gate off");
    chk_machine_pass: assert property (@(posedge clock) disable iff (!rstn)
        cfg1_q[1] && (machLo_q[0] && events.machine[0])
        |=> firstInterruptPin)
        else $error("machine one not passed");
    chk_high_pass: assert property (@(posedge clock) disable iff (!rstn)
        cfg1_q[1] && machHi_q[7] && events.machine[15]
        |=> firstInterruptPin)
        else $error("machine sixteen not passed");
    chk_class_pass: assert property (@(posedge clock) disable iff (!rstn)
        cfg1_q[1] && cls_q[7] && events.classifier[7]
        |=> firstInterruptPin)
        else $error("classifier eight not passed");
    chk_tilt_pass: assert property (@(posedge clock) disable iff (!rstn)
        cfg2_q[1] && pin2_q[4] && events.tilt
        |=> secondInterruptPin)
        else $error("tilt not passed");
    chk_block_two: assert property (@(posedge clock) disable iff (!rstn)
        pin2_q == 8'h0 |=> !secondInterruptPin)
        else $error("pin two active with no routes");
    chk_read_back: assert property (@(posedge clock) disable iff (!rstn)
        wrEn && wordIdx == 8'h0e ##1 wb_ack_o ##1 !req ##1
        req && !wb_we_i && wordIdx == 8'h0e && pin2_q == $past(wrByte, 3)
        |=> wb_dat_o[7:0] == pin2_q)
        else $error("pin two register read back wrong");
    chk_ack_pulse: assert property (@(posedge clock) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    chk_pin_two_or: assert property (@(posedge clock) disable iff (!rstn)
        secondInterruptPin == $past(pin2_d))
        else $error("pin two not from routed OR");
    chk_block_one: assert property (@(posedge clock) disable iff (!rstn)
        machLo_q == 8'h00 && machHi_q == 8'h00 && cls_q == 8'h00
        |=> !firstInterruptPin)
        else $error("pin one active with no routes");
    chk_eight_pass: assert property (@(posedge clock) disable iff (!rstn)
        cfg1_q[eeir_pkg::POS_GATE] && machLo_q[7] && events.machine[7]
        |=> firstInterruptPin)
        else $error("machine eight not passed");
    chk_nine_pass: assert property (@(posedge clock) disable iff (!rstn)
        cfg1_q[eeir_pkg::POS_GATE] && machHi_q[0] && events.machine[8]
        |=> firstInterruptPin)
        else $error("machine nine not passed");
    chk_class_one: assert property (@(posedge clock) disable iff (!rstn)
        cfg1_q[eeir_pkg::POS_GATE] && cls_q[0]
        && events.classifier[0] |=> firstInterruptPin)
        else $error("classifier one not passed");
    chk_long_pass: assert property (@(posedge clock) disable iff (!rstn)
        cfg2_q[eeir_pkg::POS_GATE] && pin2_q[eeir_pkg::POS_LONG_CNT]
        && events.longCounter |=> secondInterruptPin)
        else $error("long counter not passed");
    chk_motion_pass: assert property (@(posedge clock) disable iff (!rstn)
        cfg2_q[eeir_pkg::POS_GATE] && pin2_q[eeir_pkg::POS_SIG_MOT]
        && events.sigMotion |=> secondInterruptPin)
        else $error("significant motion not passed");
    chk_step_pass: assert property (@(posedge clock) disable iff (!rstn)
        cfg2_q[eeir_pkg::POS_GATE] && pin2_q[eeir_pkg::POS_STEP]
        && events.step |=> secondInterruptPin)
        else $error("step event not passed");
    chk_unused_blind: assert property (@(posedge clock) disable iff (!rstn)
        (pin2_q & eeir_pkg::PIN2_USED_MASK) == 8'h00
        |=> !secondInterruptPin)
        else $error("unused pin two bit routes an event");
    chk_route_drop: assert property (@(posedge clock) disable iff (!rstn)
        $fell(machLo_q[7]) && machLo_q == 8'h00 && machHi_q == 8'h00
        && cls_q == 8'h00 |=> !firstInterruptPin)
        else $error("cleared route still drives pin one");
    chk_reset_all: assert property (@(posedge clock)
        $rose(rstn) |-> machHi_q == 8'h00 && cls_q == 8'h00)
        else $error("route regs not cleared by reset");
    chk_mask_reset: assert property (@(posedge clock)
        $rose(rstn) |-> irqMask_q == eeir_pkg::IRQ_RST)
        else $error("mask not cleared by reset");
    chk_low_lands: assert property (@(posedge clock) disable iff (!rstn)
        wrEn && wordIdx == eeir_pkg::IDX_MACH_LO
        |=> machLo_q == $past(wrByte))
        else $error("low machine route write lost");
    chk_high_lands: assert property (@(posedge clock) disable iff (!rstn)
        wrEn && wordIdx == eeir_pkg::IDX_MACH_HI
        |=> machHi_q == $past(wrByte))
        else $error("high machine route write lost");
    chk_cls_lands: assert property (@(posedge clock) disable iff (!rstn)
        wrEn && wordIdx == eeir_pkg::IDX_CLS
        |=> cls_q == $past(wrByte))
        else $error("classifier route write lost");
    chk_two_lands: assert property (@(posedge clock) disable iff (!rstn)
        wrEn && wordIdx == eeir_pkg::IDX_PIN2
        |=> pin2_q == $past(wrByte))
        else $error("pin two route write lost");
    chk_stat_set: assert property (@(posedge clock) disable iff (!rstn)
        rise[eeir_pkg::POS_IRQ_PIN1] |=> irqStat_q[eeir_pkg::POS_IRQ_PIN1])
        else $error("pin one status not set");
    chk_stat_clear: assert property (@(posedge clock) disable iff (!rstn)
        clr[eeir_pkg::POS_IRQ_PIN1] && !rise[eeir_pkg::POS_IRQ_PIN1]
        |=> !irqStat_q[eeir_pkg::POS_IRQ_PIN1])
        else $error("pin one status not cleared");
    chk_irq_level: assert property (@(posedge clock) disable iff (!rstn)
        irq == $past(|(irqStat_q & irqMask_q)))
        else $error("irq not from masked status");
    chk_ack_follows: assert property (@(posedge clock) disable iff (!rstn)
        req && busState_q == eeir_pkg::EEIR_IDLE |=> wb_ack_o)
        else $error("request not acknowledged");
    chk_unmapped_zero: assert property (@(posedge clock) disable iff (!rstn)
        req && busState_q == eeir_pkg::EEIR_IDLE
        && wordIdx > eeir_pkg::IDX_IRQ_MASK |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");

    // one pass check per machine bit of pin one
    for (genvar m = 0; m < 16; m++) begin : g_mach
        chk_mach_pass: assert property (@(posedge clock)
            disable iff (!rstn)
            cfg1_q[eeir_pkg::POS_GATE] && {machHi_q, machLo_q}[m]
            && events.machine[m] |=> firstInterruptPin)
            else $error("machine event not passed");
    end

    // one pass check per classifier bit of pin one
    for (genvar c = 0; c < 8; c++) begin : g_cls
        chk_cls_pass: assert property (@(posedge clock)
            disable iff (!rstn)
            cfg1_q[eeir_pkg::POS_GATE] && cls_q[c]
            && events.classifier[c] |=> firstInterruptPin)
            else $error("classifier event not passed");
    end

    cov_pin_one: cover property (@(posedge clock) $rose(firstInterruptPin));
    cov_pin_two: cover property (@(posedge clock) $rose(secondInterruptPin));
    cov_irq: cover property (@(posedge clock) $rose(irq));
    cov_write: cover property (@(posedge clock) wrEn);
endmodule

// ### test/eeir_host_model.sv
// ****************************************
// host side: counts rising edges per pin
// ****************************************
module eeir_host_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic pinOne,
    input wire logic pinTwo,
    output logic [7:0] risesOne_q,
    output logic [7:0] risesTwo_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lastOne_q;
    logic lastTwo_q;
    // pins are high-active levels; an edge is one host event
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lastOne_q <= 1'b0;
            lastTwo_q <= 1'b0;
            risesOne_q <= 8'h00;
            risesTwo_q <= 8'h00;
        end else begin
            lastOne_q <= pinOne;
            lastTwo_q <= pinTwo;
            if (pinOne && !lastOne_q) risesOne_q <= risesOne_q + 8'h01;
            if (pinTwo && !lastTwo_q) risesTwo_q <= risesTwo_q + 8'h01;
        end
    end
endmodule

// ### test/tb_embedded_event_irq_routing.sv
module tb_embedded_event_irq_routing;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] rt;
        logic [1:0] gate;
        logic [27:0] ev;
        logic [1:0] pins;
    } eeir_row_t;
    localparam eeir_row_t ROWS[14] = '{
        {32'h00000000, 2'h3, 28'hfffffff, 2'h0},
        {32'h80000000, 2'h3, 28'h0080000, 2'h2},
        {32'h80000000, 2'h3, 28'h0001000, 2'h0},
        {32'h00010000, 2'h3, 28'h0100000, 2'h2},
        {32'h00800000, 2'h3, 28'h8000000, 2'h2},
        {32'h00800000, 2'h1, 28'h8000000, 2'h0},
        {32'h00008000, 2'h3, 28'h0000800, 2'h2},
        {32'h00000080, 2'h3, 28'h0000008, 2'h1},
        {32'h00000020, 2'h3, 28'h0000004, 2'h1},
        {32'h00000010, 2'h3, 28'h0000002, 2'h1},
        {32'h00000008, 2'h3, 28'h0000001, 2'h1},
        {32'h00000008, 2'h2, 28'h0000001, 2'h0},
        {32'h00000080, 2'h3, 28'h0000001, 2'h0},
        {32'h01000008, 2'h3, 28'h0001001, 2'h3}};
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [eeir_pkg::ADDR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] datO;
    logic ack, pinOne, pinTwo, irq;
    logic [7:0] risesOne, risesTwo, q, base;
    eeir_pkg::eeir_events_t ev = '0;
    int num_errors = 0;
    int total_checks = 0;
    always #12.5 clock = ~clock;
    eeir_top dut (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(datO), .wb_ack_o(ack), .events(ev),
        .firstInterruptPin(pinOne), .secondInterruptPin(pinTwo), .irq(irq));
    eeir_host_model host (.clock(clock), .rstn(rstn), .pinOne(pinOne),
        .pinTwo(pinTwo), .risesOne_q(risesOne), .risesTwo_q(risesTwo));
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t byte %h, want %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t bit %b, want %b", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        sel <= 4'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) chk1(1'b0, 1'b1);
        q = datO[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [9:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk8(q, exp);
    endtask
    task settle(input eeir_pkg::eeir_events_t e);
        @(posedge clock);
        ev <= e;
        @(posedge clock);
        #1;
    endtask
    task end_of_test;
        $display("errors %0d, checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #(25ns * 6000);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        // ****************************************
        // table of routing cases
        // ****************************************
        foreach (ROWS[i]) begin
            wb(1'b1, 10'h178, {6'h0, ROWS[i].gate[1], 1'b0});
            wb(1'b1, 10'h17c, {6'h0, ROWS[i].gate[0], 1'b0});
            for (int r = 0; r < 4; r++) begin
                wb(1'b1, 10'h2c + 10'(4 * r), ROWS[i].rt[31-8*r -: 8]);
            end
            settle(ROWS[i].ev);
            chk1(pinOne, ROWS[i].pins[1]);
            chk1(pinTwo, ROWS[i].pins[0]);
            for (int r = 0; r < 4; r++) begin
                rd(10'h2c + 10'(4 * r), ROWS[i].rt[31-8*r -: 8]);
            end
        end
        // ****************************************
        // hand-written cases
        // ****************************************
        wb(1'b1, 10'h2c, 8'h00);
        wb(1'b1, 10'h38, 8'h00);
        rd(10'h38, 8'h00);
        wb(1'b1, 10'h1c0, 8'h03);
        wb(1'b1, 10'h1c4, 8'h00);
        settle(28'h0080000);
        base = risesOne;
        wb(1'b1, 10'h2c, 8'h80);
        repeat (2) @(posedge clock);
        #1;
        chk1(pinOne, 1'b1);
        chk8(risesOne, base + 8'h01);
        rd(10'h1c0, 8'h01);
        chk1(irq, 1'b0);
        wb(1'b1, 10'h1c4, 8'h01);
        repeat (2) @(posedge clock);
        #1;
        chk1(irq, 1'b1);
        wb(1'b1, 10'h2c, 8'h00);
        #1;
        chk1(pinOne, 1'b0);
        wb(1'b1, 10'h1c0, 8'h01);
        repeat (2) @(posedge clock);
        #1;
        chk1(irq, 1'b0);
        rd(10'h1c0, 8'h00);
        wb(1'b1, 10'h3fc, 8'hff);
        rd(10'h3fc, 8'h00);
        wb(1'b1, 10'h34, 8'hff);
        settle(28'hfffffff);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        chk1(pinOne, 1'b0);
        chk1(pinTwo, 1'b0);
        chk1(irq, 1'b0);
        chk8(risesOne, 8'h00);
        chk8(risesTwo, 8'h00);
        for (int r = 0; r < 4; r++) begin
            rd(10'h2c + 10'(4 * r), 8'h00);
        end
        end_of_test();
    end
endmodule
